// >>> rtl/usb_stat_ctrl_pkg.sv
// Purpose: constants for the usb error, status fifo and control block
// Assumes: apb with 32-bit data, one word per register
// Notes: offsets are byte addresses
package usb_stat_ctrl_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_ERR_FLAGS = 8'h00;
	localparam logic [7:0] OFS_ERR_EN = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0C;
	localparam logic [7:0] OFS_IRQ = 8'h10;
	// field positions
	localparam int B_TOKCRC = 1;
	localparam int B_PID = 0;
	localparam int B_STUFF = 7;
	localparam int B_MATRIX = 6;
	localparam int B_DMA = 5;
	localparam int B_BTO = 4;
	localparam int B_DFN = 3;
	localparam int B_CRC16 = 2;
	localparam int C_JST = 7;
	localparam int C_SE0 = 6;
	localparam int C_HOLD = 5;
	localparam int C_RST = 4;
	localparam int C_HOST = 3;
	localparam int C_RESUME = 2;
	localparam int C_PPB = 1;
	localparam int C_EN = 0;
	localparam int I_TRN = 3;
	localparam int I_GEN = 1;
	localparam int STAT_DIR = 3;
	localparam int STAT_BANK = 2;
	localparam int FIFO_DEPTH = 4;
	localparam int BTO_BITS = 16;
	// low-speed eop after resume: two bit-times at 1.5 Mb/s, ns
	localparam int LS_EOP_NS = 1333;
	localparam int CLK_NS = 10;
	localparam int LS_EOP_CYC = LS_EOP_NS / CLK_NS;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RD_ZERO = 32'h00000000;
endpackage

// >>> rtl/usb_stat_ctrl.sv
// Purpose: usb error flags, error enables, transfer status fifo, module control
// Assumes: one clock; usb engine events arrive as one-cycle pulses on the core clock
// Notes: bus line levels come from pins and are synchronised here
`timescale 1ns/1ns

module usb_stat_ctrl #(
	parameter int BIT_CYC = 8
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RESETN,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [usb_stat_ctrl_pkg::ADDR_W-1:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_LINE_J,
	input wire logic I_LINE_SE0,
	input wire logic I_TOKEN_CRC_FAIL,
	input wire logic I_SOF_CNT_ZERO,
	input wire logic I_LINK_ACTIVE,
	input wire logic I_PID_FAIL,
	input wire logic I_STUFF_FAIL,
	input wire logic I_MATRIX_FAIL,
	input wire logic I_DMA_LATE,
	input wire logic I_PKT_TRUNC,
	input wire logic I_PARTIAL_BYTE,
	input wire logic I_CRC16_FAIL,
	input wire logic I_EOP_SEEN,
	input wire logic I_RESP_SEEN,
	input wire logic I_SETUP_RX,
	input wire logic I_TOKEN_START,
	input wire logic I_TOKEN_DONE,
	input wire logic [3:0] I_DONE_EP,
	input wire logic I_DONE_TX,
	input wire logic I_DONE_ODD,
	output logic O_USB_IRQ,
	output logic O_HOST_MODE,
	output logic O_HOST_LOGIC_RST,
	output logic O_BUS_RESET_DRIVE,
	output logic O_RESUME_DRIVE,
	output logic O_LS_EOP_DRIVE,
	output logic O_BANK_PTR_CLEAR,
	output logic O_MODULE_ENABLE,
	output logic O_SOF_GEN_ENABLE,
	output logic O_PKT_HOLD
);
	import usb_stat_ctrl_pkg::*;

	typedef enum logic [1:0] {RS_IDLE = 2'b00, RS_DRIVE = 2'b01, RS_EOP = 2'b11} resume_t;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic wr_acc, rd_ok;
	logic [7:0] wb;
	assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
	assign wb = I_PWDATA[7:0];
	assign O_PREADY = 1'b1;
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction
	assign rd_ok = hit(I_PADDR, OFS_ERR_FLAGS) || hit(I_PADDR, OFS_ERR_EN)
		|| hit(I_PADDR, OFS_STAT) || hit(I_PADDR, OFS_CTRL) || hit(I_PADDR, OFS_IRQ);
	// unmapped addresses answer with an error, writes discarded
	assign O_PSLVERR = I_PSEL && I_PENABLE && !rd_ok;

	// ----------------------------------------------------------------
	// line level synchronisers
	// ----------------------------------------------------------------
	logic [2:0] j_sync_q, se0_sync_q;
	logic j_live_q, se0_live_q;
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN) begin
			j_sync_q <= 3'h0;
			se0_sync_q <= 3'h0;
		end else begin
			j_sync_q <= {j_sync_q[1:0], I_LINE_J};
			se0_sync_q <= {se0_sync_q[1:0], I_LINE_SE0};
		end
	end
	// change taken only when stages two and three agree
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN) begin
			j_live_q <= 1'b0;
			se0_live_q <= 1'b0;
		end else begin
			if (j_sync_q[1] == j_sync_q[2])
				j_live_q <= j_sync_q[2];
			if (se0_sync_q[1] == se0_sync_q[2])
				se0_live_q <= se0_sync_q[2];
		end
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	logic host_q, rst_drv_q, resume_q, en_q, hold_q, busy_q, host_prev_q, ppb_q;
	logic ctrl_wr;
	assign ctrl_wr = wr_acc && hit(I_PADDR, OFS_CTRL);
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN) begin
			host_q <= 1'b0;
			rst_drv_q <= 1'b0;
			resume_q <= 1'b0;
			en_q <= 1'b0;
		end else if (ctrl_wr) begin
			host_q <= wb[C_HOST];
			rst_drv_q <= wb[C_RST];
			resume_q <= wb[C_RESUME];
			en_q <= wb[C_EN];
		end
	end
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN)
			host_prev_q <= 1'b0;
		else
			host_prev_q <= host_q;
	end
	assign O_HOST_LOGIC_RST = host_q != host_prev_q;
	// one-cycle pulse on write of one
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN)
			ppb_q <= 1'b0;
		else
			ppb_q <= ctrl_wr && wb[C_PPB];
	end
	assign O_BANK_PTR_CLEAR = ppb_q;
	// setup sets hold in device mode; software clears by writing zero, host mode keeps it clear
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN || host_q)
			hold_q <= 1'b0;
		else if (I_SETUP_RX)
			hold_q <= 1'b1;
		else if (ctrl_wr)
			hold_q <= wb[C_HOLD];
	end
	// busy from token start to done in host mode only; cleared on host logic reset
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN || !host_q || O_HOST_LOGIC_RST)
			busy_q <= 1'b0;
		else if (I_TOKEN_START)
			busy_q <= 1'b1;
		else if (I_TOKEN_DONE)
			busy_q <= 1'b0;
	end
	assign O_PKT_HOLD = hold_q;
	assign O_HOST_MODE = host_q;
	// reset drive only in host mode
	assign O_BUS_RESET_DRIVE = host_q && rst_drv_q;
	assign O_MODULE_ENABLE = !host_q && en_q;
	assign O_SOF_GEN_ENABLE = host_q && en_q;

	// ----------------------------------------------------------------
	// resume sequencer
	// ----------------------------------------------------------------
	resume_t rs_q;
	logic [$clog2(LS_EOP_CYC+1)-1:0] eop_cnt_q;
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN) begin
			rs_q <= RS_IDLE;
			eop_cnt_q <= '0;
		end else begin
			unique case (rs_q)
				RS_IDLE: if (resume_q) rs_q <= RS_DRIVE;
				// eop appended only in host mode
				RS_DRIVE: if (!resume_q) begin
					rs_q <= host_q ? RS_EOP : RS_IDLE;
					eop_cnt_q <= '0;
				end
				RS_EOP: begin
					eop_cnt_q <= eop_cnt_q + 1'b1;
					if (eop_cnt_q == ($bits(eop_cnt_q))'(LS_EOP_CYC - 1))
						rs_q <= RS_IDLE;
				end
				default: rs_q <= RS_IDLE;
			endcase
		end
	end
	assign O_RESUME_DRIVE = rs_q == RS_DRIVE;
	assign O_LS_EOP_DRIVE = rs_q == RS_EOP;

	// ----------------------------------------------------------------
	// turnaround timer
	// ----------------------------------------------------------------
	localparam int BTO_CYC = BTO_BITS * BIT_CYC;
	logic [$clog2(BTO_CYC+2)-1:0] bto_cnt_q;
	logic bto_arm_q, bto_hit;
	// count idle after eop until response
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN || I_RESP_SEEN) begin
			bto_arm_q <= 1'b0;
			bto_cnt_q <= '0;
		end else if (I_EOP_SEEN) begin
			bto_arm_q <= 1'b1;
			bto_cnt_q <= '0;
		end else if (bto_arm_q) begin
			bto_cnt_q <= bto_cnt_q + 1'b1;
			if (bto_hit)
				bto_arm_q <= 1'b0;
		end
	end
	assign bto_hit = bto_arm_q && !I_EOP_SEEN && !I_RESP_SEEN
		&& bto_cnt_q == ($bits(bto_cnt_q))'(BTO_CYC);

	// ----------------------------------------------------------------
	// error flags and enables
	// ----------------------------------------------------------------
	logic [7:0] eflag_q, een_q, eset;
	logic gen_en_q;
	always_comb begin
		eset = 8'h00;
		eset[B_TOKCRC] = host_q ? (I_SOF_CNT_ZERO && I_LINK_ACTIVE) : I_TOKEN_CRC_FAIL;
		eset[B_PID] = I_PID_FAIL;
		eset[B_DMA] = I_DMA_LATE || I_PKT_TRUNC;
		eset[B_BTO] = bto_hit;
		eset[B_STUFF] = I_STUFF_FAIL;
		eset[B_MATRIX] = I_MATRIX_FAIL;
		eset[B_DFN] = I_PARTIAL_BYTE;
		eset[B_CRC16] = I_CRC16_FAIL;
	end
	// write one clears, set wins over clear
	generate
		for (genvar g = 0; g < 8; g++) begin : g_eflag
			always_ff @(posedge I_CORE_CLK) begin
				if (!I_RESETN)
					eflag_q[g] <= 1'b0;
				else if (eset[g])
					eflag_q[g] <= 1'b1;
				else if (wr_acc && hit(I_PADDR, OFS_ERR_FLAGS) && wb[g])
					eflag_q[g] <= 1'b0;
			end
		end
	endgenerate
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN) begin
			een_q <= RST_BYTE;
			gen_en_q <= 1'b0;
		end else begin
			if (wr_acc && hit(I_PADDR, OFS_ERR_EN))
				een_q <= wb;
			if (wr_acc && hit(I_PADDR, OFS_IRQ))
				gen_en_q <= wb[I_GEN];
		end
	end
	assign O_USB_IRQ = gen_en_q && |(eflag_q & een_q);

	// ----------------------------------------------------------------
	// transfer status fifo and token-complete flag
	// ----------------------------------------------------------------
	logic [5:0] fifo_q [FIFO_DEPTH];
	logic [1:0] rd_ptr_q, wr_ptr_q;
	logic [2:0] cnt_q;
	logic push, pop, trn_flag;
	assign push = I_TOKEN_DONE && cnt_q != 3'(FIFO_DEPTH);
	assign pop = wr_acc && hit(I_PADDR, OFS_IRQ) && wb[I_TRN] && cnt_q != 3'h0;
	// flag stands while an entry waits
	assign trn_flag = cnt_q != 3'h0;
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN) begin
			rd_ptr_q <= 2'h0;
			wr_ptr_q <= 2'h0;
			cnt_q <= 3'h0;
		end else begin
			if (push) begin
				fifo_q[wr_ptr_q] <= {I_DONE_EP, I_DONE_TX, I_DONE_ODD};
				wr_ptr_q <= wr_ptr_q + 2'h1;
			end
			if (pop)
				rd_ptr_q <= rd_ptr_q + 2'h1;
			cnt_q <= cnt_q + 3'(push) - 3'(pop);
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN)
			O_PRDATA <= RD_ZERO;
		else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
			O_PRDATA <= RD_ZERO;
			if (hit(I_PADDR, OFS_ERR_FLAGS))
				O_PRDATA[7:0] <= eflag_q;
			if (hit(I_PADDR, OFS_ERR_EN))
				O_PRDATA[7:0] <= een_q;
			if (hit(I_PADDR, OFS_STAT) && trn_flag)
				O_PRDATA[7:2] <= fifo_q[rd_ptr_q];
			if (hit(I_PADDR, OFS_CTRL))
				O_PRDATA[7:0] <= {j_live_q, se0_live_q, host_q ? busy_q : hold_q,
					rst_drv_q, host_q, resume_q, 1'b0, en_q};
			if (hit(I_PADDR, OFS_IRQ)) begin
				O_PRDATA[I_TRN] <= trn_flag;
				O_PRDATA[I_GEN] <= gen_en_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_pid_set;
		@(posedge I_CORE_CLK) disable iff (!I_RESETN) I_PID_FAIL |=> eflag_q[B_PID];
	endproperty
	a_pid_set: assert property (p_pid_set) else $error("pid flag not set");
	property p_crc_dev;
		@(posedge I_CORE_CLK) disable iff (!I_RESETN)
			(!host_q && I_TOKEN_CRC_FAIL) |=> eflag_q[B_TOKCRC];
	endproperty
	a_crc_dev: assert property (p_crc_dev) else $error("token crc flag missed");
	property p_irq_gate;
		@(posedge I_CORE_CLK) disable iff (!I_RESETN)
			O_USB_IRQ |-> gen_en_q && (eflag_q & een_q) != 8'h00;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
	property p_zero_keeps;
		@(posedge I_CORE_CLK) disable iff (!I_RESETN)
			(wr_acc && hit(I_PADDR, OFS_ERR_FLAGS) && !wb[B_PID] && eflag_q[B_PID])
			|=> eflag_q[B_PID];
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) else $error("flag lost on zero");
	property p_dma;
		@(posedge I_CORE_CLK) disable iff (!I_RESETN) I_PKT_TRUNC |=> eflag_q[B_DMA];
	endproperty
	a_dma: assert property (p_dma) else $error("dma flag missed");
	property p_pop;
		@(posedge I_CORE_CLK) disable iff (!I_RESETN)
			(pop && !push) |=> cnt_q == $past(cnt_q) - 3'h1;
	endproperty
	a_pop: assert property (p_pop) else $error("fifo did not advance");
	property p_setup_hold;
		@(posedge I_CORE_CLK) disable iff (!I_RESETN)
			(!host_q && I_SETUP_RX) |=> O_PKT_HOLD;
	endproperty
	a_setup_hold: assert property (p_setup_hold) else $error("hold not set");
	property p_host_rst;
		@(posedge I_CORE_CLK) disable iff (!I_RESETN)
			$changed(host_q) |-> O_HOST_LOGIC_RST;
	endproperty
	a_host_rst: assert property (p_host_rst) else $error("no host reset on toggle");
	property p_busrst;
		@(posedge I_CORE_CLK) disable iff (!I_RESETN) O_BUS_RESET_DRIVE |-> host_q;
	endproperty
	a_busrst: assert property (p_busrst) else $error("bus reset outside host");
endmodule

// >>> dv/usb_peer_model.sv
// Purpose: stand-in for the usb engine and bus peer feeding the status block
// Assumes: events are one-cycle pulses raised just after a rising core clock edge
// Notes: tasks are called by the bench; done fields are scrambled once stale
`timescale 1ns/1ns
module usb_peer_model (
	input wire logic i_clk,
	output logic [14:0] o_ev,
	output logic [3:0] o_ep,
	output logic o_tx,
	output logic o_odd,
	output logic o_j,
	output logic o_se0,
	output logic o_busy
);
	initial begin
		o_ev = 15'h0000;
		o_ep = 4'h0;
		o_tx = 1'b0;
		o_odd = 1'b0;
		o_j = 1'b0;
		o_se0 = 1'b0;
		o_busy = 1'b0;
	end

	// --------------------------------
	// event and transfer reporting
	// --------------------------------
	task automatic pulse(input int idx);
		@(posedge i_clk);
		o_ev[idx] <= 1'b1;
		@(posedge i_clk);
		o_ev[idx] <= 1'b0;
	endtask

	// fields valid only with the completion pulse
	task automatic done(input logic [3:0] ep, input logic tx, input logic odd);
		@(posedge i_clk);
		o_ev[14] <= 1'b1;
		o_ep <= ep;
		o_tx <= tx;
		o_odd <= odd;
		@(posedge i_clk);
		o_ev[14] <= 1'b0;
		o_ep <= ~ep;
		o_tx <= ~tx;
		o_odd <= ~odd;
	endtask

	task automatic lines(input logic j, input logic se0);
		@(posedge i_clk);
		o_j <= j;
		o_se0 <= se0;
	endtask

	task automatic act(input logic b);
		@(posedge i_clk);
		o_busy <= b;
	endtask
endmodule

// >>> dv/tb.sv
// Purpose: self-checking bench for the usb error, status fifo and control block
// Assumes: zero-wait apb slave; event pulses come from the peer model
// Notes: host/device mode flips are counted from pulse outputs
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin error_cnt++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb;
	import usb_stat_ctrl_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic pready, pslverr, irq, host, hrst, brst, resume, lseop, bclr, men, frame_start_generate_enable, hold;
	logic [14:0] ev;
	logic [3:0] ep;
	logic tx, odd, lj, lse0, busy;
	logic pid_ev, tokcrc_ev, crc16_ev, pfb_ev, eop_ev, dma_ev, matrix_ev, stuff_ev, trunc_ev;
	logic sof0_ev, resp_ev, setup_ev, tstart_ev, done_ev;
	logic [7:0] fifo_exp [5] = '{8'hA8, 8'h54, 8'hFC, 8'h00, 8'h38};
	int error_cnt = 0, n_checks = 0, cyc = 0, n_hrst = 0, n_eop = 0, n_bclr = 0, fb, k;

	usb_peer_model u_peer (.i_clk(clk), .o_ev(ev), .o_ep(ep), .o_tx(tx), .o_odd(odd),
		.o_j(lj), .o_se0(lse0), .o_busy(busy));
	// named event lines, one per design input
	assign {resp_ev, sof0_ev, trunc_ev, stuff_ev, matrix_ev, dma_ev, eop_ev, pfb_ev, crc16_ev,
		tokcrc_ev, pid_ev} = ev[10:0];
	assign {done_ev, tstart_ev, setup_ev} = ev[14:12];
	usb_stat_ctrl #(.BIT_CYC(8)) u_dut (.I_CORE_CLK(clk), .I_RESETN(rst_n), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_LINE_J(lj),
		.I_LINE_SE0(lse0), .I_TOKEN_CRC_FAIL(tokcrc_ev), .I_SOF_CNT_ZERO(sof0_ev),
		.I_LINK_ACTIVE(busy), .I_PID_FAIL(pid_ev), .I_STUFF_FAIL(stuff_ev),
		.I_MATRIX_FAIL(matrix_ev), .I_DMA_LATE(dma_ev), .I_PKT_TRUNC(trunc_ev),
		.I_PARTIAL_BYTE(pfb_ev), .I_CRC16_FAIL(crc16_ev), .I_EOP_SEEN(eop_ev),
		.I_RESP_SEEN(resp_ev), .I_SETUP_RX(setup_ev), .I_TOKEN_START(tstart_ev),
		.I_TOKEN_DONE(done_ev), .I_DONE_EP(ep), .I_DONE_TX(tx), .I_DONE_ODD(odd),
		.O_USB_IRQ(irq), .O_HOST_MODE(host), .O_HOST_LOGIC_RST(hrst),
		.O_BUS_RESET_DRIVE(brst), .O_RESUME_DRIVE(resume), .O_LS_EOP_DRIVE(lseop),
		.O_BANK_PTR_CLEAR(bclr), .O_MODULE_ENABLE(men), .O_SOF_GEN_ENABLE(frame_start_generate_enable),
		.O_PKT_HOLD(hold));

	// --------------------------------
	// clock, pulse counters, hang guard
	// --------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (hrst === 1'b1) n_hrst++;
		if (lseop === 1'b1) n_eop++;
		if (bclr === 1'b1) n_bclr++;
		if (cyc == 6000) begin
			error_cnt++;
			final_report();
		end
	end

	task final_report;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// --------------------------------
	// apb master
	// --------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// only the bench cycle ceiling ends a stuck wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] x;
		apb(1'b1, a, wd, x);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input string nm);
		apb(1'b0, a, 32'h0, d);
		`CHK(nm, ex, d)
	endtask

	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (k = 0; k < 5; k++) rdc(8'(k * 4), 32'h0, "reset value"); // flags idle
		rdc(8'h14, 32'h0, "unmapped read");
		`CHK("slverr", 1'b1, err)
		wr(OFS_ERR_EN, 32'hFFFFFFFF);
		rdc(OFS_ERR_EN, 32'h000000FF, "enables"); // eight enables
		wr(OFS_ERR_EN, 32'h0);
		for (k = 0; k < 9; k++) begin
			if (k != 4) begin
				fb = (k == 8) ? 5 : k;
				u_peer.pulse(k);
				repeat (2) @(posedge clk);
				rdc(OFS_ERR_FLAGS, 32'h1 << fb, "flag set"); // set
				wr(OFS_ERR_FLAGS, 32'h0);
				rdc(OFS_ERR_FLAGS, 32'h1 << fb, "flag kept"); // zero keeps
				wr(OFS_ERR_FLAGS, 32'h1 << fb);
				rdc(OFS_ERR_FLAGS, 32'h0, "flag clear"); // one clears
			end
		end
		u_peer.pulse(4);
		// last read that must still see no timeout, the next one must see it
		repeat (127) @(posedge clk);
		rdc(OFS_ERR_FLAGS, 32'h0, "early timeout"); // not before sixteen bits
		rdc(OFS_ERR_FLAGS, 32'h10, "timeout"); // late response
		wr(OFS_ERR_FLAGS, 32'h10);
		u_peer.pulse(4);
		u_peer.pulse(10);
		repeat (150) @(posedge clk);
		rdc(OFS_ERR_FLAGS, 32'h0, "answered"); // answered in time
		wr(OFS_ERR_EN, 32'h01);
		u_peer.pulse(0);
		repeat (2) @(posedge clk);
		`CHK("irq gen off", 1'b0, irq) // general gate
		wr(OFS_IRQ, 32'h02);
		// let the written enable settle before looking at the level
		@(posedge clk);
		`CHK("irq on", 1'b1, irq) // enabled path
		wr(OFS_ERR_EN, 32'h02);
		@(posedge clk);
		`CHK("irq masked", 1'b0, irq) // other bit masks
		wr(OFS_ERR_FLAGS, 32'h01);
		wr(OFS_CTRL, 32'h08);
		repeat (3) @(posedge clk);
		`CHK("host", 1'b1, host) // host enable
		`CHK("host rst", 1, n_hrst) // change resets
		u_peer.pulse(1);
		u_peer.act(1'b1);
		u_peer.pulse(9);
		u_peer.act(1'b0);
		repeat (2) @(posedge clk);
		rdc(OFS_ERR_FLAGS, 32'h02, "eof"); // only eof in host
		`CHK("irq eof", 1'b1, irq) // bit one gates eof
		wr(OFS_ERR_FLAGS, 32'h02);
		u_peer.pulse(13);
		repeat (2) @(posedge clk);
		rdc(OFS_CTRL, 32'h28, "tok busy"); // token running
		for (k = 0; k < 5; k++) begin
			u_peer.done(fifo_exp[k][7:4], fifo_exp[k][3], fifo_exp[k][2]);
			if (k == 0) rdc(OFS_CTRL, 32'h08, "tok idle"); // idle before next
		end
		for (k = 0; k < 4; k++) begin
			// general error enable stays set, so bit 1 reads back too
			rdc(OFS_IRQ, 32'h0A, "trn flag"); // head valid
			rdc(OFS_STAT, 32'(fifo_exp[k]), "status"); // fields
			wr(OFS_IRQ, 32'h0A); // clearing advances
		end
		rdc(OFS_IRQ, 32'h02, "fifo empty"); // four entries
		wr(OFS_CTRL, 32'h1D); // wake bit held then cleared, hold time scaled down
		repeat (2) @(posedge clk);
		`CHK("bus reset", 1'b1, brst) // reset drive
		`CHK("resume", 1'b1, resume) // resume drive
		`CHK("sof", 1'b1, frame_start_generate_enable) // sof in host
		fb = n_eop;
		wr(OFS_CTRL, 32'h08);
		repeat (LS_EOP_CYC + 10) @(posedge clk);
		`CHK("bus reset off", 1'b0, brst) // cleared ends
		`CHK("resume off", 1'b0, resume) // resume ends on clear
		`CHK("ls eop", LS_EOP_CYC, n_eop - fb) // eop appended
		wr(OFS_CTRL, 32'h01);
		repeat (3) @(posedge clk);
		`CHK("host rst2", 2, n_hrst) // either direction
		`CHK("enable", 1'b1, men) // device enable
		u_peer.pulse(12);
		repeat (2) @(posedge clk);
		rdc(OFS_CTRL, 32'h21, "setup hold"); // setup sets hold
		`CHK("hold", 1'b1, hold) // processing held
		wr(OFS_CTRL, 32'h03);
		repeat (3) @(posedge clk);
		`CHK("bank clear", 1, n_bclr) // pointers to even
		rdc(OFS_CTRL, 32'h01, "ctrl"); // cleared
		u_peer.lines(1'b1, 1'b0);
		repeat (5) @(posedge clk);
		rdc(OFS_CTRL, 32'h81, "j level"); // live j
		wr(OFS_CTRL, 32'hC1);
		u_peer.lines(1'b0, 1'b1);
		repeat (5) @(posedge clk);
		rdc(OFS_CTRL, 32'h41, "se0 level"); // read only live
		final_report();
	end
endmodule
